/* File: gpio_dual_port.sv */
/*
  gpio_dual_port: two 8-bit general purpose ports behind an apb slave;
  port b adds analog select outputs, weak pull-ups and interrupt-on-change.
  Assumes pins arrive unsynchronised and pins are resolved by the bench
  from the output and output enable signals; presetn is the power-on reset,
  warm resets (external pin, brown-out) arrive on warm_reset_n.
*/
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
module gpio_dual_port
  import gpio_pkg::*;
#(
  parameter int width = 8
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             warm_reset_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [width-1:0] port_a_in,
  output logic      [width-1:0] port_a_out,
  output logic      [width-1:0] port_a_oe,
  input  wire logic [width-1:0] port_b_in,
  output logic      [width-1:0] port_b_out,
  output logic      [width-1:0] port_b_oe,
  output logic      [width-1:0] port_b_pullup,
  output logic      [width-1:0] port_b_analog,
  output logic                  port_change_flag,
  output logic                  wake_request
);

////////////////////////////////////////////////////////////////////////////////
  logic [width-1:0] a_sync1;
  logic [width-1:0] a_sync2;
  logic [width-1:0] b_sync1;
  logic [width-1:0] b_sync2;
  logic [width-1:0] port_a_latch;
  logic [width-1:0] port_b_latch;
  logic [width-1:0] port_a_direction;
  logic [width-1:0] port_b_direction;
  logic [width-1:0] analog_select_low;
  logic [analog_high_width-1:0] analog_select_high;
  logic [width-1:0] pullup_enable_bits;
  logic [width-1:0] change_irq_enable_bits;
  logic [7:0]       option_control;
  logic [width-1:0] snapshot;
  logic             warm_sync1;
  logic             warm_sync2;
  logic [width-1:0] a_read;
  logic [width-1:0] b_read;
  logic [width-1:0] b_analog;
  logic [width-1:0] mismatch;
  logic             setup;
  logic             wr;
  logic             reg_write;
  logic             mapped;
  logic             b_access;
  logic             flag_clear;
  logic [31:0]      next_prdata;

////////////////////////////////////////////////////////////////////////////////
  // pins are asynchronous; two stages before anything looks at them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_sync1 <= '0;
      a_sync2 <= '0;
    end
    else
    begin
      a_sync1 <= port_a_in;
      a_sync2 <= a_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      b_sync1 <= '0;
      b_sync2 <= '0;
    end
    else
    begin
      b_sync1 <= port_b_in;
      b_sync2 <= b_sync1;
    end
  end

  // warm reset idles high; a low reset value would fake a warm reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warm_sync1 <= 1'b1;
      warm_sync2 <= 1'b1;
    end
    else
    begin
      warm_sync1 <= warm_reset_n;
      warm_sync2 <= warm_sync1;
    end
  end

  // per-pin analog select for port b pins 0 to 5; bits 7:6 tie to zero
  assign b_analog = {2'b00, analog_select_high[an_b5], analog_select_high[an_b4],
                     analog_select_high[an_b3], analog_select_high[an_b2],
                     analog_select_high[an_b1], analog_select_high[an_b0]};

  assign a_read = a_sync2 & ~analog_select_low;
  assign b_read = b_sync2 & ~b_analog;

  // single-cycle apb: reads and errors decode in the setup cycle, writes in the access cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign reg_write = wr & pstrb[0];
  assign b_access = psel & penable & (paddr == off_port_b_data);
  assign flag_clear = wr & (paddr == off_change_status) & pstrb[0]
                      & ~pwdata[pos_change_flag];

  always_comb
  begin
    mapped = 1'b1;
    next_prdata = '0;
    case (paddr)
      off_port_a_data:        next_prdata[7:0] = a_read;
      off_port_a_direction:   next_prdata[7:0] = port_a_direction;
      off_analog_select_low:  next_prdata[7:0] = analog_select_low;
      off_port_b_data:        next_prdata[7:0] = b_read;
      off_port_b_direction:   next_prdata[7:0] = port_b_direction;
      off_analog_select_high: next_prdata[5:0] = analog_select_high;
      off_pullup_enable_bits: next_prdata[7:0] = pullup_enable_bits;
      off_change_irq_enable:  next_prdata[7:0] = change_irq_enable_bits;
      off_option_control:     next_prdata[7:0] = option_control;
      off_change_status:      next_prdata[1:0] = {wake_request, port_change_flag};
      off_reset_control:      next_prdata = '0;
      default:                mapped = 1'b0;
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
  // bus answer: ready in the first access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup & ~mapped;
  end

  // read data is zero outside the answer cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else
      prdata <= (setup & ~pwrite) ? next_prdata : '0;
  end

////////////////////////////////////////////////////////////////////////////////
  // configuration registers; all follow the power-on reset only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_a_direction <= rst_direction;
    else if (reg_write && paddr == off_port_a_direction)
      port_a_direction <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_b_direction <= rst_direction;
    else if (reg_write && paddr == off_port_b_direction)
      port_b_direction <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_select_low <= rst_analog_low;
    else if (reg_write && paddr == off_analog_select_low)
      analog_select_low <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_select_high <= rst_analog_high;
    else if (reg_write && paddr == off_analog_select_high)
      analog_select_high <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pullup_enable_bits <= rst_pullup;
    else if (reg_write && paddr == off_pullup_enable_bits)
      pullup_enable_bits <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      change_irq_enable_bits <= rst_change_enable;
    else if (reg_write && paddr == off_change_irq_enable)
      change_irq_enable_bits <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      option_control <= rst_option;
    else if (reg_write && paddr == off_option_control)
      option_control <= pwdata[7:0];
  end

  // output latches; the write value is already the modified pin image
  // formed by software from a prior read, so the latch takes it whole
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_a_latch <= rst_latch;
    else if (reg_write && paddr == off_port_a_data)
      port_a_latch <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_b_latch <= rst_latch;
    else if (reg_write && paddr == off_port_b_data)
      port_b_latch <= pwdata[7:0];
  end

////////////////////////////////////////////////////////////////////////////////
  // snapshot survives warm resets: only power-on clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snapshot <= rst_latch;
    else if (b_access)
      snapshot <= b_read;
  end

  // the access cycle itself hides mismatch, like the phase-two window
  assign mismatch = (b_read ^ snapshot) & change_irq_enable_bits
                    & {width{~b_access}};

  // set wins over software clear; warm reset clears flag, mismatch re-sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_change_flag <= 1'b0;
    else if (|mismatch)
      port_change_flag <= 1'b1;
    else if (flag_clear || !warm_sync2)
      port_change_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_request <= 1'b0;
    else
      wake_request <= |mismatch | (port_change_flag & ~flag_clear);
  end

////////////////////////////////////////////////////////////////////////////////
  // pin drive: direction governs the driver, port a bit 3 is never driven, analog select does not
  genvar i;
  generate
    for (i = 0; i < width; i++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          port_a_out[i] <= 1'b0;
          port_a_oe[i] <= 1'b0;
        end
        else
        begin
          port_a_out[i] <= port_a_latch[i];
          port_a_oe[i] <= ~port_a_direction[i] & (i != pos_input_only_a);
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          port_b_out[i] <= 1'b0;
          port_b_oe[i] <= 1'b0;
        end
        else
        begin
          port_b_out[i] <= port_b_latch[i];
          port_b_oe[i] <= ~port_b_direction[i];
        end
      end

      // pull-up off for outputs and analog pins; global bit gates all
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          port_b_pullup[i] <= 1'b0;
        else
          port_b_pullup[i] <= pullup_enable_bits[i] & port_b_direction[i]
                              & ~option_control[pos_global_pullup_disable]
                              & ~b_analog[i];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          port_b_analog[i] <= 1'b0;
        else
          port_b_analog[i] <= b_analog[i];
      end
    end
  endgenerate

endmodule

/* File: gpio_dual_port_chk.sv */
/*
  gpio_dual_port_chk: concurrent checks on the gpio block ports.
  Assumes one clock and presetn as power-on reset.
*/
`timescale 1ns/1ns
module gpio_dual_port_chk
  import gpio_pkg::*;
#(
  parameter int width = 8
)
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             warm_reset_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic [width-1:0] port_a_oe,
  input wire logic [width-1:0] port_b_out,
  input wire logic [width-1:0] port_b_oe,
  input wire logic [width-1:0] port_b_pullup,
  input wire logic [width-1:0] port_b_analog,
  input wire logic             port_change_flag,
  input wire logic             wake_request
);
  logic [width-1:0] wd;
  logic [2:0]       wcnt;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // pwdata moves on before the pins follow, so keep the last byte
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wd <= '0;
    else if (psel && penable && pready)
      wd <= pwdata[width-1:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wcnt <= 3'd0;
    else if (!warm_reset_n)
      wcnt <= 3'd0;
    else if (wcnt != 3'd4)
      wcnt <= wcnt + 3'd1;
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_port_a_data_input: assert property (port_a_oe[3] == 1'b0)
    else $error("port a bit 3 driven");
  a_pullup_output: assert property ((port_b_pullup & port_b_oe) == '0)
    else $error("pull-up on driven pin");
  a_analog_reads: assert property (pready && !pwrite && paddr == off_port_b_data
    |-> (prdata[width-1:0] & port_b_analog) == '0) else $error("analog pin read one");
  a_dir_drives: assert property (pready && pwrite && paddr == off_port_b_direction
    |-> ##[1:2] port_b_oe == ~wd) else $error("oe not from direction");
  a_out_latch: assert property (pready && pwrite && paddr == off_port_b_data
    |-> ##[1:2] port_b_out == wd) else $error("out not from latch");
  a_reset_quiet: assert property ($rose(presetn)
    |-> port_b_pullup == '0 && port_b_oe == '0 && !port_change_flag) else $error("reset state");
  a_flag_sticky: assert property (port_change_flag && wcnt == 3'd4
    && !(pready && pwrite && paddr == off_change_status) |=> port_change_flag)
    else $error("flag dropped");
  a_wake_flag: assert property ($rose(port_change_flag) |-> ##[0:1] wake_request)
    else $error("no wake");
endmodule
bind gpio_dual_port gpio_dual_port_chk #(.width(width)) i_chk
(
  .pclk(pclk), .presetn(presetn), .warm_reset_n(warm_reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
  .port_b_pullup(port_b_pullup), .port_b_analog(port_b_analog),
  .port_change_flag(port_change_flag), .wake_request(wake_request)
);

/* File: gpio_dual_port_test.sv */
/*
  gpio_dual_port_test: apb register and pin tests of the gpio block.
  Assumes the checker is bound and port b pins come from the model.
*/
`timescale 1ns/1ns
module gpio_dual_port_test;
  import gpio_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        warm_n = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        e;
  logic        err;
  logic        flag;
  logic        wake;
  logic [7:0]  a_out, a_oe, b_out, b_oe, b_pu, b_in, q, b_an;
  logic [7:0]  ext_b = 8'hc0;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [7:0]  offs [8] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28};
  logic [7:0]  rsts [8] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h00, 8'hff, 8'h00};
  gpio_dual_port i_dut
  (
    .pclk(pclk), .presetn(presetn), .warm_reset_n(warm_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(e), .port_a_in(a_out & a_oe), .port_a_out(a_out),
    .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
    .port_b_pullup(b_pu), .port_b_analog(b_an), .port_change_flag(flag), .wake_request(wake)
  );
  gpio_pins_model i_pins
  (
    .pclk(pclk), .oe(b_oe), .out(b_out), .pull_on(b_pu), .ext(ext_b), .ext_en(8'hf0), .pin(b_in)
  );
  ////////////////////////////////////////
  initial
    forever #5 pclk = ~pclk;
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // two idle edges after each transfer let pin outputs settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata[7:0];
    err = e;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic warm_pulse;
    warm_n <= 1'b0;
    repeat (4) @(posedge pclk);
    warm_n <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i])
      rd(offs[i], rsts[i]);
    chk(b_pu, 8'h00);
    chk(b_an, 8'h3f);
    wr(off_port_b_direction, 8'hf0);
    wr(off_port_b_data, 8'ha5);
    chk(b_oe, 8'h0f);
    chk(b_out, 8'ha5);
    rd(off_port_b_data, 8'hc0);
    wr(off_analog_select_high, 8'h00);
    chk(b_an, 8'h00);
    rd(off_port_b_data, 8'hc5);
    wr(off_option_control, 8'h00);
    wr(off_pullup_enable_bits, 8'hff);
    chk(b_pu, 8'hf0);
    wr(off_pullup_enable_bits, 8'h50);
    chk(b_pu, 8'h50);
    wr(off_option_control, 8'h80);
    chk(b_pu, 8'h00);
    ext_b <= 8'hf0;
    wr(off_change_irq_enable, 8'hf0);
    rd(off_port_b_data, 8'hf5);
    wr(off_change_status, 8'h00);
    rd(off_change_status, 8'h00);
    warm_pulse;
    rd(off_change_status, 8'h00);
    ext_b <= 8'h70;
    repeat (5) @(posedge pclk);
    rd(off_change_status, 8'h03);
    chk({6'h00, wake, flag}, 8'h03);
    warm_pulse;
    rd(off_change_status, 8'h03);
    wr(off_change_status, 8'h00);
    rd(off_change_status, 8'h03);
    rd(off_port_b_data, 8'h75);
    wr(off_change_status, 8'h00);
    rd(off_change_status, 8'h00);
    chk({6'h00, wake, flag}, 8'h00);
    wr(off_change_irq_enable, 8'h00);
    wr(off_analog_select_high, 8'h08);
    chk(b_an, 8'h10);
    rd(off_port_b_data, 8'h65);
    wr(off_port_a_direction, 8'h00);
    wr(off_port_a_data, 8'hff);
    chk(a_oe, 8'hf7);
    chk(a_out, 8'hff);
    rd(off_port_a_data, 8'h00);
    wr(off_analog_select_low, 8'h00);
    rd(off_port_a_data, 8'hf7);
    rd(8'h2c, 8'h00);
    chk({7'h00, err}, 8'h01);
    end_of_test;
  end
endmodule

/* File: gpio_pins_model.sv */
/*
  gpio_pins_model: circuits outside port b, resolves each pin level.
  Assumes oe high means the block drives the pin.
*/
`timescale 1ns/1ns
module gpio_pins_model
(
  input  wire logic       pclk,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] ext,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin
);
  logic [7:0] last = 8'h00;
  ////////////////////////////////////////
  // a floating pin flips each cycle, so no stale level reads as valid
  // unknown levels count as low so the float toggle cannot stick at x
  always_ff @(posedge pclk)
    for (int k = 0; k < 8; k++)
      last[k] <= (pin[k] === 1'b1);
  assign pin = (oe & out) | (~oe & ext_en & ext)
             | (~oe & ~ext_en & (pull_on | ~last));
endmodule

/* File: gpio_pkg.sv */
/*
  gpio_pkg: register offsets, reset values and field positions for the dual
  8-bit gpio block. Assumes a 32-bit apb slave with word-aligned registers.
*/
package gpio_pkg;
  localparam logic [7:0] off_port_a_data        = 8'h00;
  localparam logic [7:0] off_port_a_direction   = 8'h04;
  localparam logic [7:0] off_analog_select_low  = 8'h08;
  localparam logic [7:0] off_port_b_data        = 8'h0c;
  localparam logic [7:0] off_port_b_direction   = 8'h10;
  localparam logic [7:0] off_analog_select_high = 8'h14;
  localparam logic [7:0] off_pullup_enable_bits = 8'h18;
  localparam logic [7:0] off_change_irq_enable  = 8'h1c;
  localparam logic [7:0] off_option_control     = 8'h20;
  localparam logic [7:0] off_change_status      = 8'h24;
  localparam logic [7:0] off_reset_control      = 8'h28;

  localparam logic [7:0] rst_direction          = 8'hff;
  localparam logic [7:0] rst_analog_low         = 8'hff;
  localparam logic [5:0] rst_analog_high        = 6'h3f;
  localparam logic [7:0] rst_pullup             = 8'hff;
  localparam logic [7:0] rst_change_enable      = 8'h00;
  localparam logic [7:0] rst_option             = 8'hff;
  localparam logic [7:0] rst_latch              = 8'h00;

  localparam int pos_global_pullup_disable      = 7;
  localparam int pos_input_only_a               = 3;
  localparam int pos_change_flag                = 0;
  localparam int pos_sleep_wake                 = 1;
  localparam int pos_soft_reset                 = 0;
  localparam int analog_high_width              = 6;
  // mapping of port-b pins onto the six high analog select bits
  localparam int an_b0 = 4, an_b1 = 2, an_b2 = 0, an_b3 = 1, an_b4 = 3, an_b5 = 5;
endpackage
